//--- src/setpoint_relay_controller.sv
// Functional notes
// - Program plus up enters setpoint mode
// - Make delay 0..9999 s, continuous alarm
// - Break delay 0..9999 s, continuous clear
// - Deadband split half above, half below
// - Delays only on trip points one, two
// - Program press stores field and advances
// - High over trip, low below trip
// - Four direction codes, point one leftmost
// - Two relays restrict to four codes
// - Points three, four skipped in menu only when both relays missing
// - Program on direction code exits
// - Duplicate relays switch in unison
// - Dim pin halves brightness
// - Hold freezes shown reading
// - Lock refuses all changes
// - Fifteen seconds idle leaves programming
//
// The Avalon-MM register port and the address map were left to the implementer.
`default_nettype none
module setpoint_relay_controller
  import setpoint_relay_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES  // Cycles per second, shorten in sim
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        btn_prog_n,
  input  wire logic        btn_up_n,
  input  wire logic        btn_down_n,
  input  wire logic        dim_n,
  input  wire logic        hold_n,
  input  wire logic        lock_n,
  input  wire logic [3:0]  relay_fitted,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_address,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [3:0]       relay_main,
  output logic [1:0]       relay_module,
  output logic [2:0]       brightness_out,
  output logic [15:0]      display_value,
  output logic             irq
);
  // Refuse a second length that the tick counter cannot serve
  if (SEC_CYC < 1) begin : g_sec_check
    $error("SEC_CYC must be positive");
  end

  // Clamp a signed value into the display range
  function automatic logic signed [15:0] clamp(input logic signed [16:0] v, input logic signed [16:0] lo);
    if (v > 17'sd9999) clamp = 16'sd9999;
    else if (v < lo)   clamp = lo[15:0];
    else               clamp = v[15:0];
  endfunction : clamp

  // Two-stage synchronisers for all key and switch pins
  logic [5:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_s1_r <= 6'h3F;
      pin_s2_r <= 6'h3F;
    end else begin
      pin_s1_r <= {btn_prog_n, btn_up_n, btn_down_n, dim_n, hold_n, lock_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  // Active when pulled low
  wire prog_lvl = ~pin_s2_r[5];
  wire up_lvl   = ~pin_s2_r[4];
  wire dn_lvl   = ~pin_s2_r[3];
  wire dim_on   = ~pin_s2_r[2];
  wire hold_on  = ~pin_s2_r[1];
  wire lock_on  = ~pin_s2_r[0];

  // Button press edges
  logic [2:0] btn_prev_r;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) btn_prev_r <= 3'h0;
    else          btn_prev_r <= {prog_lvl, up_lvl, dn_lvl};
  end
  wire prog_p = prog_lvl & ~btn_prev_r[2];
  wire up_p   = up_lvl   & ~btn_prev_r[1];
  wire dn_p   = dn_lvl   & ~btn_prev_r[0];
  wire any_p  = prog_p | up_p | dn_p;

  // Second tick generator
  logic [31:0] sec_cnt_r;
  logic        sec_tick;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) sec_cnt_r <= 32'h0;
    else if (sec_cnt_r == 32'(SEC_CYC - 1)) sec_cnt_r <= 32'h0;
    else sec_cnt_r <= sec_cnt_r + 32'h1;
  end
  assign sec_tick = (sec_cnt_r == 32'(SEC_CYC - 1));

  // Stored parameters
  logic signed [15:0] trip_r [4];      // trip_point_one..four
  logic        [15:0] band_r [4];      // deadband_width per point
  logic        [15:0] make_r [2];      // Make delays
  logic        [15:0] brk_r  [2];      // Break delays
  logic        [1:0]  dir_idx_r;       // relay_direction_code index
  logic        [2:0]  bright_r;        // Programmed brightness
  logic [1:0]  point_r;                // Menu point index
  menu_t       menu_r;                 // Menu field
  logic signed [15:0] edit_r;          // Value under edit
  logic [4:0]  idle_r;                 // Idle seconds
  logic        exit_ev;                // Menu left pulse
  logic        refuse_ev;              // Lock refusal pulse
  wire two_only = ~relay_fitted[2] & ~relay_fitted[3];

  // Direction bits per point from code index
  function automatic logic [3:0] dir_bits(input logic [1:0] idx, input logic two);
    // Bit0 = point one; 1 = high activation
    if (two) begin
      case (idx)
        2'h0: dir_bits = 4'h2;   // Lh--
        2'h1: dir_bits = 4'h1;   // hL--
        2'h2: dir_bits = 4'h3;   // hh--
        default: dir_bits = 4'h0;  // LL--
      endcase
    end else begin
      case (idx)
        2'h0: dir_bits = 4'h0;   // LLLL
        2'h1: dir_bits = 4'hA;   // LhLh
        2'h2: dir_bits = 4'h5;   // hLhL
        default: dir_bits = 4'hF;  // hhhh
      endcase
    end
  endfunction : dir_bits
  wire [3:0] dir_now = dir_bits(dir_idx_r, two_only);

  // Current field stored value
  logic signed [15:0] field_val;
  always_comb begin
    case (menu_r)
      M_TRIP:  field_val = trip_r[point_r];
      M_MAKE:  field_val = make_r[point_r[0]];
      M_BREAK: field_val = brk_r[point_r[0]];
      M_BAND:  field_val = band_r[point_r];
      M_DIR:   field_val = {14'h0, dir_idx_r};
      default: field_val = 16'h0;
    endcase
  end
  // Field lower limit
  wire signed [16:0] field_lo = (menu_r == M_TRIP) ? 17'(VAL_MIN) : 17'sd0;
  wire signed [16:0] field_hi = (menu_r == M_DIR) ? 17'sd3 : 17'(VAL_MAX);

  // Current point is the last one in the menu: point four, or point two when relays three and four are both missing
  wire last_pt = (point_r == 2'h3) || (point_r == 2'h1 && two_only);

  // Menu state machine
  always_ff @(posedge clk_sys) begin
    exit_ev   <= 1'b0;
    refuse_ev <= 1'b0;
    if (!reset_n) begin
      menu_r  <= M_RUN;
      point_r <= 2'h0;
      edit_r  <= 16'h0;
      idle_r  <= 5'h0;
    end else begin
      if (any_p) idle_r <= 5'h0;
      else if (sec_tick && menu_r != M_RUN) idle_r <= idle_r + 5'h1;
      case (menu_r)
        M_RUN: if (prog_lvl && up_lvl && (prog_p || up_p)) begin
          menu_r  <= M_TRIP;
          point_r <= 2'h0;
          edit_r  <= trip_r[0];
          idle_r  <= 5'h0;
        end
        default: begin
          if (idle_r == 5'(IDLE_SECONDS)) begin
            menu_r  <= M_RUN;
            exit_ev <= 1'b1;
          end else if (prog_p) begin
            case (menu_r)
              M_TRIP: begin
                menu_r <= point_r[1] ? M_BAND : M_MAKE;
                edit_r <= point_r[1] ? $signed(band_r[point_r]) : $signed(make_r[point_r[0]]);
              end
              M_MAKE: begin
                menu_r <= M_BREAK;
                edit_r <= brk_r[point_r[0]];
              end
              M_BREAK: begin
                menu_r <= M_BAND;
                edit_r <= band_r[point_r];
              end
              M_BAND: if (last_pt) begin
                menu_r <= M_DIR;
                edit_r <= {14'h0, dir_idx_r};
              end else begin
                menu_r  <= M_TRIP;
                point_r <= point_r + 2'h1;
                edit_r  <= trip_r[point_r + 2'h1];
              end
              default: begin  // Direction code stored, leave
                menu_r  <= M_RUN;
                exit_ev <= 1'b1;
              end
            endcase
          end else if ((up_p || dn_p) && lock_on) begin
            refuse_ev <= 1'b1;
          end else if (up_p) begin
            edit_r <= (17'(edit_r) + 17'sd1 > field_hi) ? field_hi[15:0] : edit_r + 16'sd1;
          end else if (dn_p) begin
            edit_r <= clamp(17'(edit_r) - 17'sd1, field_lo);
          end
        end
      endcase
    end
  end

  // Parameter store, commit on program press only
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        trip_r[i] <= DEF_TRIP;
        band_r[i] <= DEF_DEADBAND;
      end
      for (int i = 0; i < 2; i++) begin
        make_r[i] <= 16'h0;
        brk_r[i]  <= 16'h0;
      end
      dir_idx_r <= DEF_DIR_CODE;
    end else if (prog_p && !lock_on && menu_r != M_RUN && idle_r != 5'(IDLE_SECONDS)) begin
      case (menu_r)
        M_TRIP:  trip_r[point_r]    <= edit_r;
        M_MAKE:  make_r[point_r[0]] <= edit_r;
        M_BREAK: brk_r[point_r[0]]  <= edit_r;
        M_BAND:  band_r[point_r]    <= edit_r;
        M_DIR:   dir_idx_r          <= edit_r[1:0];
        default: ;
      endcase
    end
  end

  // Conversion input and held display
  logic signed [15:0] reading_r;
  logic               conv_r;      // New conversion pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) display_value <= 16'h0;
    else if (menu_r != M_RUN) display_value <= edit_r;
    else if (!hold_on) display_value <= reading_r;
  end

  // Next alarm state of one point, half the deadband on each side of the trip
  function automatic logic alarm_next(input logic cur, input logic high, input logic signed [15:0] val,
                                      input logic signed [15:0] trip, input logic [15:0] band);
    logic signed [17:0] hi_t;  // Upper edge of the band
    logic signed [17:0] lo_t;  // Lower edge of the band
    hi_t = 18'(trip) + $signed({3'h0, band[15:1]});
    lo_t = 18'(trip) - $signed({3'h0, band[15:1]});
    if (high) alarm_next = cur ? (18'(val) >= lo_t) : (18'(val) > hi_t);
    else      alarm_next = cur ? (18'(val) <= hi_t) : (18'(val) < lo_t);
  endfunction : alarm_next

  // Alarm evaluation with split deadband
  logic [3:0]  alarm_r;
  logic [3:0]  relay_r;
  logic [13:0] tmr_r [2];
  always_ff @(posedge clk_sys) begin
    if (!reset_n) alarm_r <= 4'h0;
    else if (conv_r) begin
      for (int i = 0; i < 4; i++)
        alarm_r[i] <= alarm_next(alarm_r[i], dir_now[i], reading_r, trip_r[i], band_r[i]);
    end
  end

  // Relay timers for points one and two, plain for three and four
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      relay_r  <= 4'h0;
      tmr_r[0] <= 14'h0;
      tmr_r[1] <= 14'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (alarm_r[i] == relay_r[i]) tmr_r[i] <= 14'h0;  // Restart on lapse
        else if ({2'h0, tmr_r[i]} >= (alarm_r[i] ? make_r[i] : brk_r[i]))
          relay_r[i] <= alarm_r[i];
        else if (sec_tick) tmr_r[i] <= tmr_r[i] + 14'h1;
      end
      relay_r[3:2] <= alarm_r[3:2];
    end
  end

  // Relay outputs, missing relays display only
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      relay_main   <= 4'h0;
      relay_module <= 2'h0;
    end else begin
      relay_main   <= relay_r & relay_fitted;
      relay_module <= relay_r[1:0] & relay_fitted[1:0];
    end
  end

  // Brightness, halved while dim held
  always_ff @(posedge clk_sys) begin
    if (!reset_n) brightness_out <= 3'h0;
    else brightness_out <= dim_on ? (bright_r >> 1) : bright_r;
  end

  // Event sticky status and mask
  logic [2:0] status_r, mask_r;
  logic [3:0] relay_prev_r;
  wire  [2:0] ev = {refuse_ev, exit_ev, relay_r != relay_prev_r};
  wire        wr = avs_write && !avs_waitrequest;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_r     <= 3'h0;
      relay_prev_r <= 4'h0;
    end else begin
      relay_prev_r <= relay_r;
      // Set wins over write-one clear
      status_r <= (status_r & ~((wr && avs_address == ADDR_STATUS) ? avs_writedata[2:0] : 3'h0)) | ev;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) irq <= 1'b0;
    else irq <= |(status_r & mask_r);
  end

  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      mask_r          <= 3'h0;
      bright_r        <= 3'h4;
      reading_r       <= 16'h0;
      conv_r          <= 1'b0;
    end else begin
      conv_r <= 1'b0;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (wr) begin
        case (avs_address)
          ADDR_MASK:    mask_r   <= avs_writedata[2:0];
          ADDR_BRIGHT:  bright_r <= avs_writedata[2:0];
          ADDR_READING: begin
            reading_r <= avs_writedata[15:0];
            conv_r    <= 1'b1;
          end
          default: ;
        endcase
      end
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          ADDR_STATUS:  avs_readdata <= {29'h0, status_r};
          ADDR_MASK:    avs_readdata <= {29'h0, mask_r};
          ADDR_READING: avs_readdata <= {16'h0, reading_r};
          ADDR_DISPLAY: avs_readdata <= {16'h0, display_value};
          ADDR_RELAYS:  avs_readdata <= {20'h0, 4'(menu_r), 2'h0, point_r, relay_r};
          ADDR_BRIGHT:  avs_readdata <= {29'h0, bright_r};
          ADDR_FITTED:  avs_readdata <= {28'h0, relay_fitted};
          default:      avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Checks
  sequence s_prog_edge; prog_p && menu_r == M_DIR && idle_r != 5'(IDLE_SECONDS); endsequence
  chk_dir_exit: assert property (@(posedge clk_sys) disable iff (!reset_n) s_prog_edge |=> menu_r == M_RUN)
    else $error("program on direction code did not exit");
  chk_lock_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    lock_on && menu_r != M_RUN |=> $stable(dir_idx_r))
    else $error("parameter changed under lock");
  chk_unison_relay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    relay_module == (relay_main[1:0] & relay_fitted[1:0]) || $changed(relay_fitted))
    else $error("duplicate relays differ");
  chk_dim_half: assert property (@(posedge clk_sys) disable iff (!reset_n)
    dim_on |=> brightness_out == ($past(bright_r) >> 1))
    else $error("dim did not halve");
  chk_hold_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_on && menu_r == M_RUN && $past(menu_r) == M_RUN |=> $stable(display_value))
    else $error("held display moved");
  chk_skip_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    menu_r != M_RUN |-> !(point_r[1] && (menu_r == M_MAKE || menu_r == M_BREAK)))
    else $error("delay field on late point");
  chk_enter_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    menu_r == M_RUN && prog_lvl && up_lvl && prog_p |=> menu_r == M_TRIP && point_r == 2'h0)
    else $error("setpoint mode not entered");
  chk_idle_exit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    menu_r != M_RUN && idle_r == 5'(IDLE_SECONDS) |=> menu_r == M_RUN)
    else $error("idle timeout ignored");
  chk_no_make_early: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(relay_r[0]) |-> {2'h0, $past(tmr_r[0])} >= make_r[0])
    else $error("relay made before delay");
  chk_field_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(menu_r) && menu_r != M_RUN |-> edit_r == field_val)
    else $error("edit not loaded from stored field");
endmodule : setpoint_relay_controller
`default_nettype wire

//--- src/setpoint_relay_pkg.sv
`default_nettype none
package setpoint_relay_pkg;
  localparam int          CLK_HZ          = 25_000_000;  // System clock rate
  localparam int          SEC_CYCLES      = CLK_HZ;      // Cycles per second tick
  localparam int          IDLE_SECONDS    = 15;          // Menu timeout in seconds
  localparam int          DELAY_MAX       = 9999;        // Largest delay setting
  localparam int          VAL_MIN         = -1999;       // Lowest value
  localparam int          VAL_MAX         = 9999;        // Highest value
  localparam logic [15:0] DEF_TRIP        = 16'h03E8;    // Default trip point
  localparam logic [15:0] DEF_DEADBAND    = 16'h000A;    // Default deadband
  localparam logic [1:0]  DEF_DIR_CODE    = 2'h3;        // Default direction index
  // Address map of the register bus
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;        // Sticky event bits
  localparam logic [3:0]  ADDR_MASK       = 4'h1;        // Interrupt mask
  localparam logic [3:0]  ADDR_READING    = 4'h2;        // Conversion input
  localparam logic [3:0]  ADDR_DISPLAY    = 4'h3;        // Shown reading
  localparam logic [3:0]  ADDR_RELAYS     = 4'h4;        // Relay and menu state
  localparam logic [3:0]  ADDR_BRIGHT     = 4'h5;        // Brightness level
  localparam logic [3:0]  ADDR_FITTED     = 4'h6;        // Fitted relays
  localparam int          ST_RELAY_CHG    = 0;           // Relay changed
  localparam int          ST_MENU_EXIT    = 1;           // Menu left
  localparam int          ST_LOCK_REFUSE  = 2;           // Edit refused
  typedef enum logic [3:0] {
    M_RUN, M_TRIP, M_MAKE, M_BREAK, M_BAND, M_DIR
  } menu_t;
endpackage : setpoint_relay_pkg
`default_nettype wire

//--- tb/panel_switch_model.sv
`default_nettype none
module panel_switch_model (
  input  wire logic clk_sys,
  output logic      btn_prog_n,
  output logic      btn_up_n,
  output logic      btn_down_n,
  output logic      dim_n,
  output logic      hold_n,
  output logic      lock_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open contacts rest at the pull-up level
  initial begin
    {btn_prog_n, btn_up_n, btn_down_n} = 3'h7;
    {dim_n, hold_n, lock_n}             = 3'h7;
  end
  // One press of a key set {prog, up, down}, long enough for the synchroniser
  task automatic press(input logic [2:0] keys);
    @(posedge clk_sys);
    {btn_prog_n, btn_up_n, btn_down_n} <= ~keys;
    repeat (8) @(posedge clk_sys);
    {btn_prog_n, btn_up_n, btn_down_n} <= 3'h7;
    repeat (8) @(posedge clk_sys);
  endtask : press
  // Rear switches close to common when set
  task automatic pins(input logic [2:0] dim_hold_lock);
    @(posedge clk_sys);
    {dim_n, hold_n, lock_n} <= ~dim_hold_lock;
    repeat (6) @(posedge clk_sys);
  endtask : pins
endmodule : panel_switch_model
`default_nettype wire

//--- tb/setpoint_relay_controller_tb.sv
`default_nettype none
module setpoint_relay_controller_tb
  import setpoint_relay_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 10;            // Shortened second
  logic        clk_sys;               // System clock
  logic        reset_n;               // Sync reset
  logic        btn_prog_n;            // Program key
  logic        btn_up_n;              // Up key
  logic        btn_down_n;            // Down key
  logic        dim_n;                 // Dim switch
  logic        hold_n;                // Hold switch
  logic        lock_n;                // Lock switch
  logic [3:0]  relay_fitted;          // Fitted relays
  logic        avs_read;              // Read strobe
  logic        avs_write;             // Write strobe
  logic [3:0]  avs_address;           // Word index
  logic [31:0] avs_writedata;         // Write data
  logic [31:0] avs_readdata;          // Read data
  logic        avs_waitrequest;       // Bus stall
  logic [3:0]  relay_main;            // Main relays
  logic [1:0]  relay_module;          // Module relays
  logic [2:0]  brightness_out;        // Display level
  logic [15:0] display_value;         // Shown value
  logic        irq;                   // Interrupt
  int          error_cnt;             // Mismatches
  int          check_count;           // Comparisons
  logic [31:0] q;                     // Scratch read
  setpoint_relay_controller #(.SEC_CYC(SEC)) setpoint_relay_controller_i (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .btn_prog_n      (btn_prog_n),
    .btn_up_n        (btn_up_n),
    .btn_down_n      (btn_down_n),
    .dim_n           (dim_n),
    .hold_n          (hold_n),
    .lock_n          (lock_n),
    .relay_fitted    (relay_fitted),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_address     (avs_address),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .relay_main      (relay_main),
    .relay_module    (relay_module),
    .brightness_out  (brightness_out),
    .display_value   (display_value),
    .irq             (irq)
  );
  panel_switch_model panel_switch_model_i (
    .clk_sys    (clk_sys),
    .btn_prog_n (btn_prog_n),
    .btn_up_n   (btn_up_n),
    .btn_down_n (btn_down_n),
    .dim_n      (dim_n),
    .hold_n     (hold_n),
    .lock_n     (lock_n)
  );
  // Clock source
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50) chk(32'h0, 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Bounded wait for a relay pattern, module copies compared too
  task automatic wait_relay(input logic [3:0] exp, input int lim);
    int n;
    n = 0;
    while (relay_main !== exp && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk({28'h0, relay_main}, {28'h0, exp});
    chk({30'h0, relay_module}, {30'h0, exp[1:0]});
  endtask : wait_relay
  task automatic menu_is(input logic [3:0] m);
    rd(ADDR_RELAYS, 32'h0000_0F00, {20'h0, m, 8'h00});
  endtask : menu_is
  task automatic prog_n(input int n);
    repeat (n) panel_switch_model_i.press(3'h4);
  endtask : prog_n
  // Reset values, unmapped read, dim pin
  task automatic t_regs;
    rd(ADDR_BRIGHT, 32'hFFFF_FFFF, 32'h0000_0004);
    rd(ADDR_FITTED, 32'hFFFF_FFFF, 32'h0000_000F);
    rd(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({29'h0, brightness_out}, 32'h4);
    panel_switch_model_i.pins(3'h4);
    chk({29'h0, brightness_out}, 32'h2);
    wr(ADDR_BRIGHT, 32'h6);
    cyc(2);
    chk({29'h0, brightness_out}, 32'h3);
    rd(ADDR_BRIGHT, 32'hFFFF_FFFF, 32'h0000_0006);
    panel_switch_model_i.pins(3'h0);
    chk({29'h0, brightness_out}, 32'h6);
  endtask : t_regs
  // Hold freezes the shown reading
  task automatic t_hold;
    wr(ADDR_READING, 32'h0000_01F4);
    cyc(4);
    chk({16'h0, display_value}, 32'h01F4);
    panel_switch_model_i.pins(3'h2);
    wr(ADDR_READING, 32'h0000_0258);
    cyc(4);
    chk({16'h0, display_value}, 32'h01F4);
    rd(ADDR_DISPLAY, 32'h0000_FFFF, 32'h0000_01F4);
    rd(ADDR_READING, 32'h0000_FFFF, 32'h0000_0258);
    panel_switch_model_i.pins(3'h0);
    chk({16'h0, display_value}, 32'h0258);
  endtask : t_hold
  // Deadband of 10 around 1000, interrupt mask and clear
  task automatic t_band;
    wr(ADDR_MASK, 32'h1);
    rd(ADDR_MASK, 32'h7, 32'h1);
    wr(ADDR_READING, 32'd1004);
    cyc(3 * SEC);
    chk({28'h0, relay_main}, 32'h0);
    wr(ADDR_READING, 32'd1006);
    wait_relay(4'hF, 3 * SEC);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_READING, 32'd996);
    cyc(3 * SEC);
    chk({28'h0, relay_main}, 32'hF);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_READING, 32'd994);
    wait_relay(4'h0, 3 * SEC);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    wr(ADDR_STATUS, 32'h7);
    rd(ADDR_STATUS, 32'h7, 32'h0);
  endtask : t_band
  // Edit then idle: menu left, edit dropped
  task automatic t_idle;
    panel_switch_model_i.press(3'h6);
    panel_switch_model_i.press(3'h2);
    chk({16'h0, display_value}, 32'h03E9);
    cyc(12 * SEC);
    menu_is(4'h1);
    cyc(4 * SEC);
    menu_is(4'h0);
    rd(ADDR_STATUS, 32'h2, 32'h2);
  endtask : t_idle
  // Full field order with four relays
  task automatic t_walk;
    logic [5:0] w [14] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h05, 6'h09, 6'h0D,
                          6'h11, 6'h06, 6'h12, 6'h07, 6'h13, 6'h14, 6'h00};
    panel_switch_model_i.press(3'h6);
    chk({16'h0, display_value}, 32'h03E8);
    for (int i = 0; i < 14; i++) begin
      if (i > 0) prog_n(1);
      rd(ADDR_RELAYS, (i < 12) ? 32'hF30 : 32'hF00, {20'h0, w[i][5:2], 2'h0, w[i][1:0], 4'h0});
    end
  endtask : t_walk
  // Make delay of three seconds on point one
  task automatic t_delay;
    panel_switch_model_i.press(3'h6);
    prog_n(1);
    repeat (3) panel_switch_model_i.press(3'h2);
    prog_n(12);
    menu_is(4'h0);
    wr(ADDR_READING, 32'd1006);
    cyc(2 * SEC - 6);
    chk({28'h0, relay_main & 4'h5}, 32'h4);
    wait_relay(4'hF, 4 * SEC);
    wr(ADDR_READING, 32'd994);
    wait_relay(4'h0, 3 * SEC);
  endtask : t_delay
  // Lock refuses edits
  task automatic t_lock;
    panel_switch_model_i.pins(3'h1);
    panel_switch_model_i.press(3'h6);
    panel_switch_model_i.press(3'h2);
    chk({16'h0, display_value}, 32'h03E8);
    rd(ADDR_STATUS, 32'h4, 32'h4);
    cyc(17 * SEC);
    panel_switch_model_i.pins(3'h0);
  endtask : t_lock
  // Two relays: short menu and all four direction codes
  task automatic t_two;
    logic [1:0] hi [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    relay_fitted <= 4'h3;
    for (int k = 3; k >= 0; k--) begin
      if (k < 3) begin
        panel_switch_model_i.press(3'h6);
        prog_n(8);
        menu_is(4'h5);
        panel_switch_model_i.press(3'h1);
        prog_n(1);
        menu_is(4'h0);
      end
      wr(ADDR_READING, 32'd1006);
      wait_relay({2'h0, hi[k]}, 6 * SEC);
      wr(ADDR_READING, 32'd994);
      wait_relay({2'h0, ~hi[k]}, 6 * SEC);
    end
  endtask : t_two
  // Main sequence
  initial begin
    error_cnt = 0;
    check_count = 0;
    reset_n = 1'b0;
    relay_fitted = 4'hF;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    cyc(2);
    reset_n <= 1'b1;
    t_regs();
    t_hold();
    t_band();
    t_idle();
    t_walk();
    t_delay();
    t_lock();
    t_two();
    summarize();
  end
  // Hang guard
  initial begin
    cyc(60000);
    error_cnt++;
    summarize();
  end
endmodule : setpoint_relay_controller_tb
`default_nettype wire
